//--- hw/_unused_guard.sv
// spare source slot, holds no design unit

//--- hw/ecc_word_check.sv
// single-error-correcting, double-error-detecting check of one memory word
`timescale 1ns/1ps
`default_nettype none
module ecc_word_check
    import fault_alarm_pkg::*;
(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset,
    // word in: bit 0 overall parity, bit i check or data at position i
    input  wire logic [31:0] rawWord,
    input  wire logic        rawValid,
    // result
    output logic      [31:0] fixedWord,
    output logic             fixedValid,
    output logic             corrected,
    output logic             uncorrectable
);
    typedef struct packed {
        logic [31:0] word;
        logic        valid;
        logic        cor;
        logic        unc;
    } ecc_state_t;

    ecc_state_t st_r;
    ecc_state_t st_nxt;

    // xor of positions of all set bits
    function automatic logic [4:0] syndrome(input logic [31:0] w);
        logic [4:0] s;
        s = 5'h00;
        for (int i = 1; i < 32; i++)
            if (w[i]) s = s ^ 5'(i);
        return s;
    endfunction

    // ------------------------------------------------------------
    // correction
    // ------------------------------------------------------------
    always_comb
    begin
        logic [4:0] syn;
        logic       par;
        syn = syndrome(rawWord);
        par = ^rawWord;
        st_nxt = st_r;
        st_nxt.valid = rawValid;
        st_nxt.cor = 1'b0;
        st_nxt.unc = 1'b0;
        if (rawValid)
        begin
            st_nxt.word = rawWord;
            if (par)
            begin
                st_nxt.word[syn] = ~rawWord[syn];
                st_nxt.cor = 1'b1;
            end
            else if (syn != 5'h00)
                st_nxt.unc = 1'b1;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset) st_r <= '0;
        else st_r <= st_nxt;
    end

    assign fixedWord     = st_r.word;
    assign fixedValid    = st_r.valid;
    assign corrected     = st_r.cor;
    assign uncorrectable = st_r.unc;
endmodule // ecc_word_check
`default_nettype wire

//--- hw/fault_alarm_ctrl.sv
// fault alarm, secure state and security reset controller
//
// Implementation choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Memory words are checked by an error code and single-bit errors are corrected.
// - An uncorrectable error raises an alarm, and a critical one also a security alarm and reset.
// - Results of both cores are compared and a mismatch is recorded and forces the reset sequence.
// - A failed or torn page program leaves the old page active and valid, restart is by power-on.
// - New page data is verified before the new page replaces the old one in the link table.
// - Every bus handshake is monitored and a handshake that does not complete raises an alarm.
// - A detected physical attack halts processing at once and enters security reset.
// - Physical page placement is reshuffled on every page change, without software involvement.
// - A software refresh moves a page to a spare slot chosen from write count and randomness.
// - The page link table is internal and cannot be read or written by software.
// - A low clock frequency sensor raises an alarm and is covered by the self-check.
// - A check value is computed over the memory words to find bit faults in the read-only memory.
// - A watchdog timer and a program-flow checkpoint register are offered to software.
// - An illegal operation code is detected and triggers a security reset.
module fault_alarm_ctrl
    import fault_alarm_pkg::*;
#(
    parameter int VW = 4,
    parameter int SW = 2,
    parameter int PW = 5
)(
    // clock and reset
    input  wire logic          core_clk,
    input  wire logic          reset,
    // apb slave
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [11:0]   paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    // detector inputs
    input  wire logic [31:0]   memWord,
    input  wire logic          memWordValid,
    input  wire logic          romWordValid,
    input  wire logic          romScanDone,
    input  wire logic [31:0]   cpuAResult,
    input  wire logic [31:0]   cpuBResult,
    input  wire logic          cpuResultValid,
    input  wire logic          busReq,
    input  wire logic          busAck,
    input  wire logic          attackSensor,
    input  wire logic          lowClockAlarm,
    input  wire logic          illegalOpcode,
    input  wire logic          startupDone,
    input  wire logic [7:0]    randomByte,
    // corrected memory data
    output logic      [31:0]   memFixedWord,
    output logic               memFixedValid,
    // page programming
    output logic               nvmProgStart,
    output logic               nvmVerifyStart,
    output logic               nvmCopy,
    output logic      [PW-1:0] nvmSrcPage,
    output logic      [PW-1:0] nvmDstPage,
    input  wire logic          nvmProgDone,
    input  wire logic          nvmProgOk,
    input  wire logic          nvmVerifyDone,
    input  wire logic          nvmVerifyOk,
    // translation
    input  wire logic [VW-1:0] lookupVirt,
    output logic      [PW-1:0] lookupPhys,
    // alarms and reset request
    output logic               selfTestDrive,
    output logic               alarm,
    output logic               securityAlarm,
    output logic               securityResetReq,
    output logic               cpuHalt
);
    typedef struct packed {
        logic [NUM_CAUSES-1:0] cause;
        logic [NUM_CAUSES-1:0] crit;
        logic [NUM_CAUSES-1:0] seen;
        logic                  passed;
        logic [7:0]            scCnt;
        logic [7:0]            rstCnt;
        logic                  secAlarm;
        logic                  anyAlarm;
        logic [31:0]           wdogLoad;
        logic [31:0]           wdogCnt;
        logic [31:0]           ckpt;
        logic [7:0]            busCnt;
        logic [31:0]           romSig;
        logic [31:0]           romRef;
        page_state_t           pg;
        logic [VW-1:0]         pgVirt;
        logic [SW-1:0]         pgSel;
        logic                  progStart;
        logic                  started;
        logic                  verStart;
        logic                  copy;
        logic [PW-1:0]         src;
        logic [PW-1:0]         dst;
        logic [31:0]           rdata;
        logic                  err;
    } ctrl_state_t;

    ctrl_state_t st_r;
    ctrl_state_t st_nxt;

    // ------------------------------------------------------------
    // submodules
    // ------------------------------------------------------------
    logic          eccCor;
    logic          eccUnc;
    logic [SW-1:0] candSel;
    logic [PW-1:0] candPhys;
    logic [PW-1:0] curPhys;
    logic          commit;

    ecc_word_check u_ecc (
        .core_clk      (core_clk),
        .reset         (reset),
        .rawWord       (memWord),
        .rawValid      (memWordValid),
        .fixedWord     (memFixedWord),
        .fixedValid    (memFixedValid),
        .corrected     (eccCor),
        .uncorrectable (eccUnc)
    );

    page_link_table #(.VW(VW), .SW(SW), .PW(PW)) u_link (
        .core_clk   (core_clk),
        .reset      (reset),
        .lookupVirt (lookupVirt),
        .lookupPhys (lookupPhys),
        .reqVirt    (st_r.pgVirt),
        .rnd        (randomByte),
        .candSel    (candSel),
        .candPhys   (candPhys),
        .curPhys    (curPhys),
        .commit     (commit),
        .commitSel  (st_r.pgSel)
    );

    // swap only after a clean verify
    assign commit = (st_r.pg == PG_COMMIT);

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    logic setup;
    logic wrEn;
    logic mapped;

    assign setup = psel && !penable;
    assign wrEn  = psel && penable && pwrite;
    assign pready = 1'b1;

    function automatic logic is_mapped(input logic [11:0] a);
        case (a)
            OFS_CAUSE, OFS_CTRL, OFS_STATUS, OFS_WDOG, OFS_KICK, OFS_CKPT,
            OFS_ROM_REF, OFS_ROM_SIG, OFS_CRIT, OFS_SELFTEST: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    assign mapped = is_mapped(paddr);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    logic [NUM_CAUSES-1:0] raw;
    logic [NUM_CAUSES-1:0] evt;
    logic [NUM_CAUSES-1:0] w1c;
    logic                  testing;
    logic                  flowBad;
    logic                  wdogFire;

    always_comb
    begin
        st_nxt = st_r;
        testing = (st_r.scCnt != 8'h00);
        w1c = '0;
        flowBad = 1'b0;
        wdogFire = (st_r.wdogLoad != 32'h0) && (st_r.wdogCnt == 32'h1);
        st_nxt.progStart = 1'b0;
        st_nxt.verStart = 1'b0;

        // bus handshake timeout counter
        if (busReq && !busAck && (st_r.busCnt != 8'(BUS_TIMEOUT_CYC)))
            st_nxt.busCnt = st_r.busCnt + 8'h01;
        else if (!busReq || busAck)
            st_nxt.busCnt = 8'h00;

        // watchdog countdown, reloads on expiry
        if (st_r.wdogLoad != 32'h0)
            st_nxt.wdogCnt = (st_r.wdogCnt <= 32'h1) ? st_r.wdogLoad : st_r.wdogCnt - 32'h1;

        // rom check value over scanned words
        if (romWordValid)
            st_nxt.romSig = {st_r.romSig[30:0], st_r.romSig[31]} ^ memWord;

        // register writes
        if (wrEn && mapped)
        begin
            case (paddr)
                OFS_CAUSE: w1c = pwdata[NUM_CAUSES-1:0];
                OFS_CTRL:
                begin
                    if (pwdata[CTRL_SELF_BIT] && startupDone && !testing)
                    begin
                        st_nxt.scCnt = 8'(SELF_CHECK_CYC);
                        st_nxt.seen = '0;
                    end
                    if ((pwdata[CTRL_PROG_BIT] || pwdata[CTRL_REFRESH_BIT]) && st_r.pg == PG_IDLE)
                    begin
                        st_nxt.pgVirt = pwdata[CTRL_PAGE_LSB +: VW];
                        st_nxt.copy = pwdata[CTRL_REFRESH_BIT];
                        st_nxt.pg = PG_PROG;
                    end
                end
                OFS_WDOG:
                begin
                    st_nxt.wdogLoad = pwdata;
                    st_nxt.wdogCnt = pwdata;
                end
                OFS_KICK: st_nxt.wdogCnt = st_r.wdogLoad;
                OFS_CKPT:
                begin
                    flowBad = (pwdata != 32'h0) && (pwdata != st_r.ckpt + 32'h1);
                    st_nxt.ckpt = pwdata;
                end
                OFS_ROM_REF: st_nxt.romRef = pwdata;
                OFS_CRIT: st_nxt.crit = pwdata[NUM_CAUSES-1:0];
                default: st_nxt.ckpt = st_r.ckpt;
            endcase
        end

        // page update sequence
        case (st_r.pg)
            PG_IDLE: st_nxt.pg = st_nxt.pg;
            PG_PROG:
            begin
                st_nxt.progStart = !st_r.started;         // one start pulse per entry
                st_nxt.started = 1'b1;
                if (nvmProgDone)
                    st_nxt.pg = nvmProgOk ? PG_VERIFY : PG_IDLE;
                if (nvmProgDone && nvmProgOk)
                    st_nxt.verStart = 1'b1;
            end
            PG_VERIFY:
            begin
                if (nvmVerifyDone)
                    st_nxt.pg = nvmVerifyOk ? PG_COMMIT : PG_IDLE;
            end
            PG_COMMIT: st_nxt.pg = PG_IDLE;
            default: st_nxt.pg = PG_IDLE;
        endcase
        if (st_r.pg == PG_IDLE && st_nxt.pg == PG_PROG)
        begin
            st_nxt.pgSel = candSel;
            st_nxt.started = 1'b0;
            st_nxt.dst = candPhys;
            st_nxt.src = curPhys;
        end

        // raw detector lines
        raw = '0;
        raw[C_ECC_UNC]  = eccUnc;
        raw[C_LOCKSTEP] = cpuResultValid && (cpuAResult != cpuBResult);
        raw[C_BUS]      = (st_r.busCnt == 8'(BUS_TIMEOUT_CYC));
        raw[C_ATTACK]   = attackSensor;
        raw[C_LOWCLK]   = lowClockAlarm;
        raw[C_ROM]      = romScanDone && (st_r.romSig != st_r.romRef);
        raw[C_WDOG]     = wdogFire;
        raw[C_FLOW]     = flowBad;
        raw[C_ILLOP]    = illegalOpcode;
        raw[C_PAGE]     = (st_r.pg == PG_PROG && nvmProgDone && !nvmProgOk) ||
                          (st_r.pg == PG_VERIFY && nvmVerifyDone && !nvmVerifyOk);
        raw[C_ECC_COR]  = eccCor;

        // self-check diverts lines into the seen mask
        evt = testing ? '0 : raw;
        if (testing)
        begin
            st_nxt.scCnt = st_r.scCnt - 8'h01;
            st_nxt.seen = st_r.seen | raw;
            if (st_r.scCnt == 8'h01)
                st_nxt.passed = ((st_r.seen | raw) == {NUM_CAUSES{1'b1}});
        end

        // sticky causes, a new event beats the clear
        st_nxt.cause = (st_r.cause & ~w1c) | evt;
        st_nxt.anyAlarm = |(st_nxt.cause & ~(NUM_CAUSES'(1) << C_ECC_COR));

        // critical events start the security reset
        if (|(evt & st_r.crit))
        begin
            st_nxt.rstCnt = 8'(SEC_RST_CYC);
            st_nxt.secAlarm = 1'b1;
            st_nxt.pg = PG_IDLE;
        end
        else if (st_r.rstCnt != 8'h00)
            st_nxt.rstCnt = st_r.rstCnt - 8'h01;
        else
            st_nxt.secAlarm = 1'b0;

        // read data captured in setup phase
        st_nxt.err = setup && !mapped;
        if (setup)
        begin
            case (paddr)
                OFS_CAUSE:    st_nxt.rdata = 32'(st_r.cause);
                OFS_CTRL:     st_nxt.rdata = {16'h0, 4'(st_r.pgVirt), 12'h0};
                OFS_STATUS:   st_nxt.rdata = {20'h0, st_r.pg, st_r.secAlarm, st_r.passed,
                                              testing, st_r.anyAlarm, 4'h0};
                OFS_WDOG:     st_nxt.rdata = st_r.wdogCnt;
                OFS_CKPT:     st_nxt.rdata = st_r.ckpt;
                OFS_ROM_REF:  st_nxt.rdata = st_r.romRef;
                OFS_ROM_SIG:  st_nxt.rdata = st_r.romSig;
                OFS_CRIT:     st_nxt.rdata = 32'(st_r.crit);
                OFS_SELFTEST: st_nxt.rdata = 32'(st_r.seen);
                default:      st_nxt.rdata = 32'h0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            st_r <= '0;
            st_r.pg <= PG_IDLE;
            st_r.crit <= CRIT_MASK_RST;
            st_r.wdogLoad <= WDOG_RST;
        end
        else
            st_r <= st_nxt;
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign prdata           = st_r.rdata;
    assign pslverr          = st_r.err && psel && penable;
    assign nvmProgStart     = st_r.progStart;
    assign nvmVerifyStart   = st_r.verStart;
    assign nvmCopy          = st_r.copy;
    assign nvmSrcPage       = st_r.src;
    assign nvmDstPage       = st_r.dst;
    assign selfTestDrive    = (st_r.scCnt != 8'h00);
    assign alarm            = st_r.anyAlarm;
    assign securityAlarm    = st_r.secAlarm;
    assign securityResetReq = (st_r.rstCnt != 8'h00);
    // halt at once on attack, held through the reset request
    assign cpuHalt          = (attackSensor && st_r.scCnt == 8'h00) || (st_r.rstCnt != 8'h00);
endmodule // fault_alarm_ctrl
`default_nettype wire

//--- hw/page_link_table.sv
// hidden virtual-to-physical page link table with spare pool
`timescale 1ns/1ps
`default_nettype none
module page_link_table
    import fault_alarm_pkg::*;
#(
    parameter int VW = 4,
    parameter int SW = 2,
    parameter int PW = 5
)(
    // clock and reset
    input  wire logic          core_clk,
    input  wire logic          reset,
    // translation
    input  wire logic [VW-1:0] lookupVirt,
    output logic      [PW-1:0] lookupPhys,
    // relocation
    input  wire logic [VW-1:0] reqVirt,
    input  wire logic [7:0]    rnd,
    output logic      [SW-1:0] candSel,
    output logic      [PW-1:0] candPhys,
    output logic      [PW-1:0] curPhys,
    input  wire logic          commit,
    input  wire logic [SW-1:0] commitSel
);
    typedef struct packed {
        logic [2**VW-1:0][PW-1:0] map;
        logic [2**SW-1:0][PW-1:0] pool;
        logic [15:0]              writes;
        logic [PW-1:0]            phys;
    } link_state_t;

    link_state_t st_r;
    link_state_t st_nxt;

    // identity map, spares above the pages
    function automatic link_state_t init_state();
        link_state_t s;
        s = '0;
        for (int i = 0; i < 2**VW; i++) s.map[i] = PW'(i);
        for (int j = 0; j < 2**SW; j++) s.pool[j] = PW'(2**VW + j);
        return s;
    endfunction

    // spare choice from write count and randomness
    assign candSel  = SW'(st_r.writes + 16'(rnd));
    assign candPhys = st_r.pool[candSel];
    assign curPhys  = st_r.map[reqVirt];

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.phys = st_r.map[lookupVirt];
        if (commit)
        begin
            st_nxt.map[reqVirt] = st_r.pool[commitSel];
            st_nxt.pool[commitSel] = st_r.map[reqVirt];
            st_nxt.writes = st_r.writes + 16'h0001;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset) st_r <= init_state();
        else st_r <= st_nxt;
    end

    assign lookupPhys = st_r.phys;
endmodule // page_link_table
`default_nettype wire

//--- pkg/fault_alarm_pkg.sv
// constants and types shared by the fault alarm and reset controller
package fault_alarm_pkg;

    // ------------------------------------------------------------
    // register map (byte offsets)
    // ------------------------------------------------------------
    localparam logic [11:0] OFS_CAUSE    = 12'h000;
    localparam logic [11:0] OFS_CTRL     = 12'h004;
    localparam logic [11:0] OFS_STATUS   = 12'h008;
    localparam logic [11:0] OFS_WDOG     = 12'h00c;
    localparam logic [11:0] OFS_KICK     = 12'h010;
    localparam logic [11:0] OFS_CKPT     = 12'h014;
    localparam logic [11:0] OFS_ROM_REF  = 12'h018;
    localparam logic [11:0] OFS_ROM_SIG  = 12'h01c;
    localparam logic [11:0] OFS_CRIT     = 12'h020;
    localparam logic [11:0] OFS_SELFTEST = 12'h024;

    // ------------------------------------------------------------
    // cause bit positions
    // ------------------------------------------------------------
    localparam int NUM_CAUSES = 11;
    localparam int C_ECC_UNC  = 0;
    localparam int C_LOCKSTEP = 1;
    localparam int C_BUS      = 2;
    localparam int C_ATTACK   = 3;
    localparam int C_LOWCLK   = 4;
    localparam int C_ROM      = 5;
    localparam int C_WDOG     = 6;
    localparam int C_FLOW     = 7;
    localparam int C_ILLOP    = 8;
    localparam int C_PAGE     = 9;
    localparam int C_ECC_COR  = 10;

    // control fields
    localparam int CTRL_SELF_BIT    = 0;
    localparam int CTRL_PROG_BIT    = 1;
    localparam int CTRL_REFRESH_BIT = 2;
    localparam int CTRL_PAGE_LSB    = 8;

    // reset values
    localparam logic [NUM_CAUSES-1:0] CRIT_MASK_RST = 11'h1ff;
    localparam logic [31:0]           WDOG_RST      = 32'h0;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ        = 200;
    localparam int BUS_TIMEOUT_NS = 100;
    localparam int SEC_RST_NS     = 500;
    localparam int SELF_CHECK_NS  = 200;
    localparam int BUS_TIMEOUT_CYC = (BUS_TIMEOUT_NS * CLK_MHZ) / 1000;
    localparam int SEC_RST_CYC     = (SEC_RST_NS * CLK_MHZ + 999) / 1000;
    localparam int SELF_CHECK_CYC  = (SELF_CHECK_NS * CLK_MHZ + 999) / 1000;

    // page update sequence
    typedef enum logic [3:0] {
        PG_IDLE   = 4'b0001,
        PG_PROG   = 4'b0010,
        PG_VERIFY = 4'b0100,
        PG_COMMIT = 4'b1000
    } page_state_t;

endpackage

//--- verification/fault_alarm_and_reset_control_tb.sv
// self-checking bench for the fault alarm controller
`timescale 1ns/1ps
`default_nettype none
module fault_alarm_and_reset_control_tb;
    import fault_alarm_pkg::*;
    logic core_clk, reset, psel, penable, pwrite, pready, pslverr, mwv, mfv, cv, att, lowc, ill, sud;
    logic pd, pok, vd, vok, ps, vs, passOk, slow, std, alm, sal, srr, halt, br;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, mw, mf, ca, q;
    logic [7:0]  rb;
    logic [4:0]  lp, keep;
    int fail_count, checked, seed, expCause, k;
    fault_alarm_ctrl dut (.core_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .memWord(mw), .memWordValid(mwv), .romWordValid(1'b0), .romScanDone(1'b0), .cpuAResult(ca),
        .cpuBResult(32'h0), .cpuResultValid(cv), .busReq(br), .busAck(1'b0), .attackSensor(att),
        .lowClockAlarm(lowc), .illegalOpcode(ill), .startupDone(sud), .randomByte(rb), .memFixedWord(mf),
        .memFixedValid(mfv), .nvmProgStart(ps), .nvmVerifyStart(vs), .nvmCopy(), .nvmSrcPage(), .nvmDstPage(),
        .nvmProgDone(pd), .nvmProgOk(pok), .nvmVerifyDone(vd), .nvmVerifyOk(vok), .lookupVirt(4'h3),
        .lookupPhys(lp), .selfTestDrive(std), .alarm(alm), .securityAlarm(sal), .securityResetReq(srr),
        .cpuHalt(halt));
    nvm_partner nvm (.core_clk, .reset, .nvmProgStart(ps), .nvmVerifyStart(vs), .passOk, .slow,
        .nvmProgDone(pd), .nvmProgOk(pok), .nvmVerifyDone(vd), .nvmVerifyOk(vok));
    // clock and random byte source
    initial begin core_clk = 0; forever #2.5 core_clk = ~core_clk; end
    always @(posedge core_clk) rb <= 8'($random(seed));
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin fail_count++; $display("MISMATCH %s expected %h seen %h", n, e, g); end
    endtask
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge core_clk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge core_clk) penable <= 1;
        n = 0;
        do begin @(posedge core_clk); n++; end while (pready !== 1'b1 && n < 50);
        q = prdata;
        chk("pslverr", {31'h0, a > OFS_SELFTEST}, {31'h0, pslverr});
        {psel, penable} <= 2'b00;
        if (n == 50) begin fail_count++; report_and_stop(); end
    endtask
    task automatic settle();
        int n;
        for (n = 0; n < 300 && (srr !== 1'b0 || ps !== 1'b0); n++) @(posedge core_clk);
        repeat (30) @(posedge core_clk);
        if (n == 300) begin fail_count++; report_and_stop(); end
    endtask
    task automatic ecc(input logic [31:0] w, input int c);
        @(posedge core_clk) {mw, mwv} <= {w, 1'b1};
        @(posedge core_clk) mwv <= 0;
        #1 chk("fixed", (c >> C_ECC_COR) ? 32'h0 : w, mf);
        expCause |= c; settle(); apb(0, OFS_CAUSE, 0); chk("cause", expCause, q);
    endtask
    initial
    begin
        {reset, psel, penable, pwrite, paddr, pwdata, mw, mwv, cv, ca, att, lowc, ill, sud, br} = '0;
        {passOk, slow, fail_count, checked, expCause} = '0;
        seed = 49;
        reset = 1;
        repeat (3) @(posedge core_clk);
        reset <= 0;
        apb(0, OFS_CRIT, 0); chk("crit_rst", 32'h1ff, q);
        apb(0, 12'h0fc, 0); chk("unmapped", 0, q);
        k = 1 + ($random(seed) & 30);
        ecc(32'h1 << k, 1 << C_ECC_COR);
        ecc(32'h28, 1 << C_ECC_UNC);
        for (k = 0; k < 5; k++)
        begin
            @(posedge core_clk) {att, lowc, ill, cv, br, ca} <= {k == 0, k == 1, k == 2, k == 3, k == 4, 32'h5a};
            #1 if (k == 0) chk("halt", 1, {31'h0, halt});
            repeat (k == 4 ? 22 : 1) @(posedge core_clk); {att, lowc, ill, cv, br} <= '0;
            expCause |= 1 << (k == 0 ? C_ATTACK : k == 1 ? C_LOWCLK : k == 2 ? C_ILLOP : k == 3 ? C_LOCKSTEP : C_BUS);
            settle(); apb(0, OFS_CAUSE, 0); chk("cause", expCause, q);
        end
        apb(1, OFS_CAUSE, 32'hffffffff); apb(0, OFS_CAUSE, 0); chk("w1c", 0, q);
        sud <= 1; apb(1, OFS_CTRL, 1);
        @(posedge core_clk) lowc <= 1; @(posedge core_clk) lowc <= 0;
        #1 chk("testing", 1, {31'h0, std});
        settle(); apb(0, OFS_SELFTEST, 0); chk("seen", 1 << C_LOWCLK, q);
        apb(0, OFS_CAUSE, 0); chk("cause_quiet", 0, q);
        slow <= 1; passOk <= 1; apb(1, OFS_CTRL, 32'h302); settle();
        chk("moved", 1, {31'h0, lp >= 5'd16}); keep = lp;
        passOk <= 0; apb(1, OFS_CTRL, 32'h302); settle();
        chk("kept", {27'h0, keep}, {27'h0, lp});
        apb(0, OFS_CAUSE, 0); chk("page_fail", 1 << C_PAGE, q);
        report_and_stop();
    end
endmodule // fault_alarm_and_reset_control_tb
`default_nettype wire

//--- verification/fault_alarm_asserts.sv
// assertion checker for the fault alarm controller
`timescale 1ns/1ps
`default_nettype none
module fault_alarm_asserts (
    // clock, reset and watched ports
    input wire logic        core_clk, reset, memWordValid, memFixedValid, cpuResultValid,
    input wire logic [31:0] cpuAResult, cpuBResult,
    input wire logic        attackSensor, lowClockAlarm, illegalOpcode, selfTestDrive, alarm,
    input wire logic        securityAlarm, securityResetReq, cpuHalt,
    input wire logic        nvmVerifyStart, nvmProgDone, nvmProgOk
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    ecc_result_late_a: assert property (memWordValid |=> memFixedValid)
        else $error("corrected word late");
    sec_alarm_pair_a: assert property ($rose(securityResetReq) |-> securityAlarm)
        else $error("security alarm missing");
    lockstep_reset_a: assert property (cpuResultValid && cpuAResult != cpuBResult && !selfTestDrive
        |=> securityResetReq) else $error("lockstep mismatch ignored");
    prog_fail_alarm_a: assert property (nvmProgDone && !nvmProgOk |-> ##[1:2] alarm)
        else $error("failed program not flagged");
    verify_order_a: assert property (nvmVerifyStart |-> $past(nvmProgDone && nvmProgOk))
        else $error("verify without good program");
    attack_halt_a: assert property (attackSensor && !selfTestDrive |-> cpuHalt)
        else $error("attack did not halt");
    reset_halt_a: assert property (securityResetReq |-> cpuHalt)
        else $error("cpu running in reset");
    low_clock_a: assert property (lowClockAlarm && !selfTestDrive |-> ##[1:2] alarm)
        else $error("low clock not flagged");
    illop_reset_a: assert property (illegalOpcode && !selfTestDrive |=> securityResetReq)
        else $error("illegal opcode ignored");
    cover property ($rose(securityResetReq));
    cover property (nvmVerifyStart);
    cover property ($rose(selfTestDrive));
endmodule // fault_alarm_asserts
bind fault_alarm_ctrl fault_alarm_asserts chk (.*);
`default_nettype wire

//--- verification/nvm_partner.sv
// behavioural page programming engine behind the controller
`timescale 1ns/1ps
`default_nettype none
module nvm_partner (
    // clock, reset, requests and test knobs
    input wire logic core_clk, reset, nvmProgStart, nvmVerifyStart, passOk, slow,
    // completion
    output logic     nvmProgDone, nvmProgOk, nvmVerifyDone, nvmVerifyOk
);
    int pc, vc;
    // answer each start after a short or long delay, status line toggles when idle
    always_ff @(posedge core_clk)
    begin
        nvmProgDone   <= (pc == 1) && !reset;
        nvmVerifyDone <= (vc == 1) && !reset;
        nvmProgOk     <= (pc == 1) ? passOk : ~nvmProgOk;
        nvmVerifyOk   <= (vc == 1) ? 1'b1 : ~nvmVerifyOk;
        pc <= reset ? 0 : nvmProgStart ? (slow ? 9 : 2) : (pc > 0 ? pc - 1 : 0);
        vc <= reset ? 0 : nvmVerifyStart ? (slow ? 9 : 2) : (vc > 0 ? vc - 1 : 0);
    end
endmodule // nvm_partner
`default_nettype wire
